//--- shared/asww_pkg.sv
package asww_pkg;

  // AXI4-Lite register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_GAIN     = 8'h04;
  localparam logic [7:0] ADDR_OFFSET   = 8'h08;
  localparam logic [7:0] ADDR_UPPER    = 8'h0C;
  localparam logic [7:0] ADDR_LOWER    = 8'h10;
  localparam logic [7:0] ADDR_INPUT    = 8'h14;
  localparam logic [7:0] ADDR_SCALED   = 8'h18;
  localparam logic [7:0] ADDR_REF      = 8'h1C;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;

  // CTRL field positions
  localparam int CTRL_ENABLE_BIT   = 0;
  localparam int CTRL_RETAIN_BIT   = 1;
  localparam int CTRL_USE_PORT_BIT = 2;
  localparam int CTRL_DEC_LSB      = 4;

  // STATUS / interrupt bit positions
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_ENABLE_BIT = 1;
  localparam int IRQ_ALARM_RISE = 0;
  localparam int IRQ_CAPTURE    = 1;
  localparam int IRQ_SATURATE   = 2;

  // Reset values
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0004;
  localparam logic [15:0] GAIN_RESET   = 16'h0064;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;
  localparam logic [15:0] MARGIN_RESET = 16'h0000;

  // Parameter limits
  localparam int GAIN_MAX     = 1000;
  localparam int OFFSET_MAX   = 10000;
  localparam int MARGIN_MAX   = 20000;
  localparam int OUT_MAX      = 32767;
  localparam int GAIN_SCALE   = 100;
  localparam int PHYS_IN_MAX  = 1000;
  localparam int DEC_MAX      = 3;

  // Source selection counts
  localparam int N_PHYS_IN   = 8;
  localparam int N_MARKER    = 64;
  localparam int N_NET_IN    = 32;
  localparam int N_PHYS_OUT  = 8;
  localparam int N_NET_OUT   = 16;
  localparam int N_SOURCES   = 128;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v,
                                               input int lim);
    if (v > 40'(lim)) begin
      return 16'(lim);
    end else if (v < -40'(lim)) begin
      return 16'(-lim);
    end else begin
      return v[15:0];
    end
  endfunction : sat16

endpackage : asww_pkg

//--- verilog/asww_scaler.sv
`timescale 1ns/100ps
module asww_scaler (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // Operands
  input  wire logic signed [15:0] value_in,
  input  wire logic signed [15:0] gain_factor,
  input  wire logic signed [15:0] offset_term,
  // Result
  output logic signed [15:0]      scaled,
  output logic                    saturated
);

  typedef struct packed {
    logic signed [15:0] scaled;
    logic               saturated;
  } asww_scl_state_t;

  asww_scl_state_t state;
  asww_scl_state_t next_state;

  logic signed [39:0] product;
  logic signed [39:0] sum;

  always_comb begin
    product = 40'(value_in) * 40'(gain_factor);
    // Quotient rounds toward zero, dropping gain fractions
    sum = product / 40'(asww_pkg::GAIN_SCALE) + 40'(offset_term);
    next_state.scaled = asww_pkg::sat16(sum, asww_pkg::OUT_MAX);
    next_state.saturated = (sum > 40'(asww_pkg::OUT_MAX)) ||
                           (sum < -40'(asww_pkg::OUT_MAX));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign scaled    = state.scaled;
  assign saturated = state.saturated;

endmodule : asww_scaler

//--- verilog/asww_source_mem.sv
`timescale 1ns/100ps
module asww_source_mem (
  // Clock
  input  wire logic        aclk,
  // Write side
  input  wire logic        wr_en,
  input  wire logic [6:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  // Read side
  input  wire logic [6:0]  rd_addr,
  output logic [15:0]      rd_data
);

  // Uninitialised contents are the owning system's concern
  logic [15:0] mem [0:asww_pkg::N_SOURCES-1];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : asww_source_mem

//--- verilog/asww_top.sv
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
// Notes on behaviour
// - Rising edge of monitor_enable captures analog_in as the reference.
// - Live input and reference are both scaled by gain then offset.
// - Alarm high while enabled and scaled input leaves the margin window.
// - Alarm low inside the window or once monitor_enable drops.
// - Gain is signed hundredths, clamped to minus ten to plus ten.
// - Offset is a signed integer clamped to plus or minus ten thousand.
// - Decimal places, zero to three, are stored only for display.
// - Input chosen among physical, marker, network or block sources.
// - Physical inputs span zero to one thousand internally.
// - Amplifier output equals input times gain plus offset.
// - Amplifier output stays within plus or minus 32767.
// - Upper and lower margins are independent, zero to twenty thousand.
// - Retentive option keeps watchdog state; otherwise reset clears it.
module asww_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog source table loading
  input  wire logic        source_wr,
  input  wire logic [6:0]  source_idx,
  input  wire logic [15:0] source_value,
  // Direct analog input and enable
  input  wire logic [15:0] analog_in_port,
  input  wire logic        monitor_enable_port,
  // Outputs
  output logic             watchdog_out,
  output logic [15:0]      scaled_out,
  output logic             irq
);

  typedef struct packed {
    logic               awready;
    logic               wready;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               arready;
    logic               rvalid;
    logic [1:0]         rresp;
    logic [31:0]        rdata;
    logic               aw_held;
    logic               w_held;
    logic [7:0]         aw_addr;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic [31:0]        ctrl;
    logic [6:0]         src_sel;
    logic signed [15:0] gain;
    logic signed [15:0] offset;
    logic [15:0]        upper;
    logic [15:0]        lower;
    logic signed [15:0] reference;
    logic               en_prev;
    logic               en_settled;
    logic               alarm;
    logic [2:0]         irq_stat;
    logic [2:0]         irq_mask;
    logic               irq;
    logic [15:0]        scaled_out;
  } asww_state_t;

  // Power-up contents; a warm reset may keep the retained fields
  asww_state_t state = '0;
  asww_state_t next_state;

  logic [15:0]        mem_data;
  logic signed [15:0] live_scaled;
  logic signed [15:0] ref_scaled;
  logic               live_sat;
  logic               ref_sat;

  // Same clamp for gain, offset and margin writes
  function automatic logic [15:0] clamp(input logic [31:0] v,
                                        input int lo,
                                        input int hi);
    if ($signed(v) > hi) begin
      return 16'(hi);
    end else if ($signed(v) < lo) begin
      return 16'(lo);
    end else begin
      return v[15:0];
    end
  endfunction : clamp

  asww_source_mem u_mem (
    .aclk    (aclk),
    .wr_en   (source_wr),
    .wr_addr (source_idx),
    .wr_data (source_value),
    .rd_addr (state.src_sel),
    .rd_data (mem_data)
  );

  // Selected source: table entry or direct port
  logic signed [15:0] analog_in;
  logic               monitor_enable;
  assign analog_in = state.ctrl[asww_pkg::CTRL_USE_PORT_BIT] ?
                     analog_in_port : mem_data;
  assign monitor_enable = monitor_enable_port |
                          state.ctrl[asww_pkg::CTRL_ENABLE_BIT];

  asww_scaler u_live (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .value_in    (analog_in),
    .gain_factor (state.gain),
    .offset_term (state.offset),
    .scaled      (live_scaled),
    .saturated   (live_sat)
  );

  asww_scaler u_ref (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .value_in    (state.reference),
    .gain_factor (state.gain),
    .offset_term (state.offset),
    .scaled      (ref_scaled),
    .saturated   (ref_sat)
  );

  logic signed [17:0] win_hi;
  logic signed [17:0] win_lo;
  logic               outside;
  logic               rise;
  logic [2:0]         events;
  logic               wr_go;
  logic               rd_go;
  logic [31:0]        wmask;
  logic [31:0]        wval;
  logic [31:0]        rval;
  logic               rd_ok;
  logic               wr_ok;

  always_comb begin
    next_state = state;
    rise = monitor_enable && !state.en_prev;
    next_state.en_prev = monitor_enable;
    next_state.en_settled = monitor_enable && state.en_prev;
    if (rise) begin
      next_state.reference = analog_in;
    end
    win_hi = 18'(ref_scaled) + 18'($signed({1'b0, state.upper}));
    win_lo = 18'(ref_scaled) - 18'($signed({1'b0, state.lower}));
    outside = (18'(live_scaled) > win_hi) || (18'(live_scaled) < win_lo);
    // Window judged every cycle; dropping enable clears at once.
    // Until the new reference has passed its scaler the alarm holds,
    // so a stale reference never raises it.
    next_state.alarm = monitor_enable &&
                       (state.en_settled ? outside : state.alarm);
    next_state.scaled_out = live_scaled;
    events = 3'b000;
    events[asww_pkg::IRQ_ALARM_RISE] = next_state.alarm && !state.alarm;
    events[asww_pkg::IRQ_CAPTURE] = rise;
    events[asww_pkg::IRQ_SATURATE] = live_sat || ref_sat;

    // AXI write channel
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
      next_state.wready = 1'b0;
    end
    wr_go = state.aw_held && state.w_held && !state.bvalid;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{state.w_strb[i]}};
    end
    wval = state.w_data;
    wr_ok = 1'b1;
    next_state.irq_stat = state.irq_stat;
    if (wr_go) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.bvalid = 1'b1;
      case (state.aw_addr)
        asww_pkg::ADDR_CTRL: begin
          next_state.ctrl = (state.ctrl & ~wmask) | (wval & wmask);
          // Decimal places only feed display, never the datapath
          if (next_state.ctrl[asww_pkg::CTRL_DEC_LSB +: 2] >
              2'(asww_pkg::DEC_MAX)) begin
            next_state.ctrl[asww_pkg::CTRL_DEC_LSB +: 2] =
              2'(asww_pkg::DEC_MAX);
          end
        end
        asww_pkg::ADDR_GAIN: next_state.gain = clamp(wval,
          -asww_pkg::GAIN_MAX, asww_pkg::GAIN_MAX);
        asww_pkg::ADDR_OFFSET: next_state.offset = clamp(wval,
          -asww_pkg::OFFSET_MAX, asww_pkg::OFFSET_MAX);
        asww_pkg::ADDR_UPPER: next_state.upper = clamp(wval,
          0, asww_pkg::MARGIN_MAX);
        asww_pkg::ADDR_LOWER: next_state.lower = clamp(wval,
          0, asww_pkg::MARGIN_MAX);
        asww_pkg::ADDR_INPUT: next_state.src_sel = wval[6:0];
        asww_pkg::ADDR_IRQ_STAT: next_state.irq_stat =
          state.irq_stat & ~wval[2:0];
        asww_pkg::ADDR_IRQ_MASK: next_state.irq_mask = wval[2:0];
        default: wr_ok = 1'b0;
      endcase
      next_state.bresp = wr_ok ? asww_pkg::RESP_OKAY : asww_pkg::RESP_SLVERR;
    end
    // Set wins over a write-one clear in the same cycle
    next_state.irq_stat = next_state.irq_stat | events;
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready = 1'b1;
    end

    // AXI read channel
    rd_go = s_axi_arvalid && state.arready;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      asww_pkg::ADDR_CTRL:     rval = state.ctrl;
      asww_pkg::ADDR_GAIN:     rval = 32'($signed(state.gain));
      asww_pkg::ADDR_OFFSET:   rval = 32'($signed(state.offset));
      asww_pkg::ADDR_UPPER:    rval = {16'h0000, state.upper};
      asww_pkg::ADDR_LOWER:    rval = {16'h0000, state.lower};
      asww_pkg::ADDR_INPUT:    rval = {25'h0000000, state.src_sel};
      asww_pkg::ADDR_SCALED:   rval = 32'($signed(state.scaled_out));
      asww_pkg::ADDR_REF:      rval = 32'($signed(state.reference));
      asww_pkg::ADDR_STATUS:   rval = {30'h00000000, monitor_enable,
                                       state.alarm};
      asww_pkg::ADDR_IRQ_STAT: rval = {29'h00000000, state.irq_stat};
      asww_pkg::ADDR_IRQ_MASK: rval = {29'h00000000, state.irq_mask};
      default: begin
        rval = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
    if (rd_go) begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rdata = rval;
      next_state.rresp = rd_ok ? asww_pkg::RESP_OKAY : asww_pkg::RESP_SLVERR;
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end
    next_state.irq = |(next_state.irq_stat & next_state.irq_mask);
  end

  // Retentive mode keeps reference and alarm across reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state.awready  <= 1'b1;
      state.wready   <= 1'b1;
      state.bvalid   <= 1'b0;
      state.bresp    <= asww_pkg::RESP_OKAY;
      state.arready  <= 1'b1;
      state.rvalid   <= 1'b0;
      state.rresp    <= asww_pkg::RESP_OKAY;
      state.rdata    <= 32'h0000_0000;
      state.aw_held  <= 1'b0;
      state.w_held   <= 1'b0;
      state.aw_addr  <= 8'h00;
      state.w_data   <= 32'h0000_0000;
      state.w_strb   <= 4'h0;
      state.src_sel  <= 7'h00;
      state.gain     <= asww_pkg::GAIN_RESET;
      state.offset   <= asww_pkg::OFFSET_RESET;
      state.upper    <= asww_pkg::MARGIN_RESET;
      state.lower    <= asww_pkg::MARGIN_RESET;
      state.irq_stat <= 3'h0;
      state.irq_mask <= 3'h0;
      state.irq      <= 1'b0;
      state.scaled_out <= 16'h0000;
      // Retain bit itself survives so the option outlives the reset
      state.ctrl     <= asww_pkg::CTRL_RESET |
                        (state.ctrl & 32'h0000_0002);
      // Scalers restart from zero, so the window waits for them to refill
      state.en_settled <= 1'b0;
      if (!state.ctrl[asww_pkg::CTRL_RETAIN_BIT]) begin
        state.reference <= 16'h0000;
        state.en_prev   <= 1'b0;
        state.alarm     <= 1'b0;
      end
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = state.awready;
  assign s_axi_wready  = state.wready;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rresp   = state.rresp;
  assign s_axi_rdata   = state.rdata;
  assign watchdog_out  = state.alarm;
  assign scaled_out    = state.scaled_out;
  assign irq           = state.irq;

endmodule : asww_top

//--- bench/asww_top_asserts.sv
`timescale 1ns/100ps
module asww_top_asserts (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Datapath
  input wire logic        source_wr,
  input wire logic [15:0] analog_in_port,
  input wire logic        monitor_enable_port,
  input wire logic        watchdog_out,
  input wire logic [15:0] scaled_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Five quiet cycles cover table read, scaler and output stages
  sequence quiet5;
    (!s_axi_awvalid && !source_wr && $stable(analog_in_port))[*5];
  endsequence

  a_write_answer: assert property
    (wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property
    (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_bvalid_holds: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rvalid_holds: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_read: assert property
    (rd_take ##0 (s_axi_araddr > 8'h28) |=>
     s_axi_rresp == asww_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_out_bounded: assert property
    (scaled_out != 16'h8000)
    else $error("scaled output out of range");
  a_alarm_clears: assert property
    (!monitor_enable_port |=> !watchdog_out)
    else $error("alarm held without enable");
  a_alarm_needs_en: assert property
    ($rose(watchdog_out) |->
     $past(monitor_enable_port) && $past(monitor_enable_port, 2) &&
     $past(monitor_enable_port, 3))
    else $error("alarm rose without enable");
  a_out_steady: assert property
    (quiet5 |=> $stable(scaled_out))
    else $error("scaled output moved with steady inputs");
endmodule : asww_top_asserts

//--- bench/asww_src_model.sv
`timescale 1ns/100ps
module asww_src_model (
  // Clock
  input wire logic        aclk,
  // Load request
  input wire logic        load,
  input wire logic [6:0]  load_idx,
  input wire logic [15:0] load_val,
  // Block output
  input wire logic [15:0] scaled_out,
  // Table loading and physical output
  output logic            source_wr,
  output logic [6:0]      source_idx,
  output logic [15:0]     source_value,
  output logic [15:0]     phys_out
);
  // Outside a load the slot lines carry junk, never the last value
  always_ff @(posedge aclk) begin
    source_wr    <= load;
    source_idx   <= load ? load_idx : ~load_idx;
    source_value <= load ? load_val : ~load_val;
  end
  // Only an analog sink takes the output; a real output needs 0..1000
  always_comb begin
    if ($signed(scaled_out) < 0) phys_out = 16'h0000;
    else if ($signed(scaled_out) > 1000) phys_out = 16'h03E8;
    else phys_out = scaled_out;
  end
endmodule : asww_src_model

//--- bench/asww_top_tb.sv
`timescale 1ns/100ps
module asww_top_tb;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } asww_note_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        source_wr, load = 1'b0, monitor_enable_port = 1'b0;
  logic [6:0]  source_idx, load_idx = 7'h00;
  logic [15:0] source_value, load_val = 16'h0, scaled_out;
  logic [15:0] analog_in_port = 16'h0;
  logic        watchdog_out, irq;
  int          mismatches = 0, n_tests = 0, x, g, o;
  int          wx[6] = '{210, 211, 195, 194, 205, 206};
  logic        wa[6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  int          sl[3] = '{0, 71, 127};
  asww_note_t  notes[$];

  always #10 aclk = ~aclk;

  asww_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .source_wr, .source_idx, .source_value, .analog_in_port,
    .monitor_enable_port, .watchdog_out, .scaled_out, .irq);
  asww_src_model src (.aclk, .load, .load_idx, .load_val, .scaled_out,
    .source_wr, .source_idx, .source_value, .phys_out());

  task automatic chk(input logic [31:0] e, input logic [31:0] s,
                     input string what);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, s);
    end
  endtask : chk

  function automatic logic [31:0] sc(input int x, input int g, input int o);
    int v;
    v = x * g / 100 + o;
    if (v > 32767) v = 32767;
    if (v < -32767) v = -32767;
    return 32'(v) & 32'h0000_FFFF;
  endfunction : sc

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = asww_pkg::RESP_OKAY);
    notes.push_back('{a, 32'h0, 32'h0, er});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // A late bready makes the slave hold its response
    s_axi_bready <= 1'($urandom_range(1));
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [31:0] m = 32'h0000_FFFF,
                    input logic [1:0] er = asww_pkg::RESP_OKAY);
    notes.push_back('{a, d, m, er});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom_range(1));
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
  endtask : rd

  // Results are judged at the handshake edge, off the oldest note
  always @(posedge aclk) begin
    asww_note_t n;
    if ((s_axi_rvalid && s_axi_rready) || (s_axi_bvalid && s_axi_bready)) begin
      n = notes.pop_front();
      if (s_axi_bvalid) chk(32'(n.r), 32'(s_axi_bresp), "bresp");
      else begin
        chk(32'(n.r), 32'(s_axi_rresp), "rresp");
        chk(n.d & n.m, s_axi_rdata & n.m, "rdata");
        if (n.a == asww_pkg::ADDR_SCALED)
          chk(n.d & n.m, 32'(scaled_out), "scaled_out");
        if (n.a == asww_pkg::ADDR_STATUS)
          chk(32'(n.d[0]), 32'(watchdog_out), "watchdog_out");
      end
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    $display("unexpected run length: expected end, seen hang");
    give_verdict();
  end

  initial begin
    void'($urandom(32'hA46DFFCD));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(asww_pkg::ADDR_CTRL, asww_pkg::CTRL_RESET, 32'h0000_0037);
    rd(asww_pkg::ADDR_GAIN, 32'(asww_pkg::GAIN_RESET));
    rd(asww_pkg::ADDR_UPPER, 32'h0);
    $display("done: reset values");
    wr(asww_pkg::ADDR_GAIN, 32'(-2000));
    rd(asww_pkg::ADDR_GAIN, 32'(-1000));
    wr(asww_pkg::ADDR_OFFSET, 32'(12000));
    rd(asww_pkg::ADDR_OFFSET, 32'(10000));
    wr(asww_pkg::ADDR_LOWER, 32'(25000));
    rd(asww_pkg::ADDR_LOWER, 32'(20000));
    $display("done: parameter limits");
    wr(asww_pkg::ADDR_CTRL, 32'h0000_0034);
    for (int i = 0; i < 8; i++) begin
      x = (i < 2) ? 32767 : $urandom_range(60000) - 30000;
      g = (i < 2) ? 1000 - i * 2000 : $urandom_range(2000) - 1000;
      o = $urandom_range(20000) - 10000;
      analog_in_port <= 16'(x);
      wr(asww_pkg::ADDR_GAIN, 32'(g));
      wr(asww_pkg::ADDR_OFFSET, 32'(o));
      repeat (6) @(posedge aclk);
      rd(asww_pkg::ADDR_SCALED, sc(x, g, o));
    end
    $display("done: amplifier");
    foreach (sl[i]) begin
      x = $urandom_range(1000);
      load_idx <= 7'(sl[i]);
      load_val <= 16'(x);
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
      // Table takes over only once the selected slot holds data
      wr(asww_pkg::ADDR_CTRL, 32'h0);
      wr(asww_pkg::ADDR_INPUT, 32'(sl[i]));
      repeat (6) @(posedge aclk);
      rd(asww_pkg::ADDR_SCALED, sc(x, g, o));
    end
    $display("done: source table");
    wr(asww_pkg::ADDR_CTRL, 32'h4);
    wr(asww_pkg::ADDR_GAIN, 32'd100);
    wr(asww_pkg::ADDR_OFFSET, 32'd0);
    wr(asww_pkg::ADDR_UPPER, 32'd10);
    wr(asww_pkg::ADDR_LOWER, 32'd5);
    analog_in_port <= 16'd200;
    monitor_enable_port <= 1'b1;
    repeat (3) @(posedge aclk);
    foreach (wx[i]) begin
      if (i == 4) wr(asww_pkg::ADDR_GAIN, 32'd200);
      if (i == 4) wr(asww_pkg::ADDR_OFFSET, 32'd7);
      analog_in_port <= 16'(wx[i]);
      repeat (5) @(posedge aclk);
      rd(asww_pkg::ADDR_STATUS, {30'h0, 1'h1, wa[i]}, 32'h3);
    end
    rd(asww_pkg::ADDR_REF, 32'd200);
    monitor_enable_port <= 1'b0;
    repeat (3) @(posedge aclk);
    rd(asww_pkg::ADDR_STATUS, 32'h0, 32'h3);
    analog_in_port <= 16'd500;
    monitor_enable_port <= 1'b1;
    repeat (5) @(posedge aclk);
    rd(asww_pkg::ADDR_REF, 32'd500);
    monitor_enable_port <= 1'b0;
    wr(asww_pkg::ADDR_CTRL, 32'h5);
    rd(asww_pkg::ADDR_STATUS, 32'h2, 32'h3);
    monitor_enable_port <= 1'b1;
    wr(asww_pkg::ADDR_CTRL, 32'h4);
    $display("done: watchdog");
    rd(asww_pkg::ADDR_IRQ_STAT, 32'h3, 32'h3);
    wr(asww_pkg::ADDR_IRQ_MASK, 32'h1);
    @(posedge aclk);
    chk(32'h1, 32'(irq), "irq");
    wr(asww_pkg::ADDR_IRQ_STAT, 32'h1);
    @(posedge aclk);
    chk(32'h0, 32'(irq), "irq");
    rd(asww_pkg::ADDR_IRQ_STAT, 32'h2, 32'h3);
    $display("done: interrupt");
    analog_in_port <= 16'd600;
    wr(asww_pkg::ADDR_CTRL, 32'h6);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'h1, 32'(watchdog_out), "watchdog_out");
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(asww_pkg::ADDR_REF, 32'd500);
    wr(asww_pkg::ADDR_CTRL, 32'h4);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk(32'h0, 32'(watchdog_out), "watchdog_out");
    aresetn <= 1'b1;
    @(posedge aclk);
    $display("done: retention");
    rd(8'h2C, 32'h0, 32'hFFFF_FFFF, asww_pkg::RESP_SLVERR);
    wr(8'h30, 32'h0, asww_pkg::RESP_SLVERR);
    $display("done: unmapped");
    repeat (2) @(posedge aclk);
    give_verdict();
  end
endmodule : asww_top_tb

bind asww_top asww_top_asserts chk_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .source_wr,
  .analog_in_port, .monitor_enable_port, .watchdog_out, .scaled_out);
